/* File: verilog/aivc_interp.sv */
// frame receiver, executor and replier for rotate right and indexed variable commands
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// R1: rotate right drives toward increasing position, velocity from accumulator.
// R2: rotate right selects velocity mode before touching target velocity.
// R3: then the accumulator is copied into axis parameter 2.
// R4: rotate right is opcode 51 (0x33); other fields ignored.
// R5: set indexed writes the frame value into user variable X.
// R6: X negative or above 255 makes indexed commands do nothing.
// R7: set indexed is opcode 0x37 with value in the four value bytes.
// R8: get indexed, opcode 0x38, loads accumulator from user variable X.
// R9: accumulator store, opcode 0x39, writes accumulator to user variable X.
// R10: each of the four commands replies with status 100.
// R11: frame is address, opcode, type, bank, value MSB first, checksum.
// R12: checksum is byte sum of first eight, checked before execution.
module aivc_interp #(
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter logic [7:0] HOST_ADDR = 8'h02
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] rxByte,
    input wire logic rxValid,
    output logic rxReady,
    output logic [7:0] txByte,
    output logic txValid,
    input wire logic txReady,
    input wire logic accuLoad,
    input wire logic [31:0] accuLoadValue,
    input wire logic [31:0] xIndex,
    output logic [31:0] accu,
    output logic velocityMode,
    output logic moveRight,
    output logic axisParamWrite,
    output logic [7:0] axisParamIndex,
    output logic [31:0] axisParamValue
);
    import aivc_pkg::*;

    logic [1:0] rstSync;
    logic rstN;
    aivc_state_type state;
    aivc_state_type next_state;
    logic [3:0] rxCount;
    logic [7:0] rxSum;
    logic sumOk;
    logic [7:0] frameAddr;
    logic [7:0] frameCmd;
    logic [31:0] frameValue;
    logic [7:0] replyStatus;
    logic [3:0] txCount;
    logic [31:0] userVar [256];
    logic take;
    logic addrOk;
    logic inRange;
    logic frameGood;
    logic known;
    logic txDone;
    logic [7:0] replySum;

    ////////////////////////////////////////////////////////////////
    // reset release

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    ////////////////////////////////////////////////////////////////
    // frame reception

    assign take = rxValid && rxReady;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            rxCount <= RST_COUNT;
            rxSum <= RST_BYTE;
            sumOk <= 1'b0;
            frameAddr <= RST_BYTE;
            frameCmd <= RST_BYTE;
            frameValue <= RST_WORD;
        end else if (take) begin
            if (rxCount == LAST_BYTE) begin
                sumOk <= (rxSum == rxByte); // R12
                rxSum <= RST_BYTE;
                rxCount <= RST_COUNT;
            end else begin
                rxSum <= rxSum + rxByte; // R12
                rxCount <= rxCount + 4'h1;
            end
            if (rxCount == RST_COUNT) begin
                frameAddr <= rxByte; // R11
            end
            if (rxCount == 4'h1) begin
                frameCmd <= rxByte; // R11
            end
            if (rxCount >= VALUE_FIRST && rxCount < LAST_BYTE) begin
                frameValue <= {frameValue[23:0], rxByte}; // R11
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // decode and sequencing

    assign addrOk = (frameAddr == MODULE_ADDR);
    assign inRange = (xIndex[31:8] == INDEX_HIGH_ZERO); // R6
    assign frameGood = addrOk && sumOk; // R12
    assign known = (frameCmd == OP_ROTATE_RIGHT) || (frameCmd == OP_SET_INDEXED)
        || (frameCmd == OP_GET_INDEXED) || (frameCmd == OP_ACCU_TO_INDEXED);
    assign txDone = (txCount == FRAME_LEN) && (!txValid || txReady);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_RECV: begin
                if (take && rxCount == LAST_BYTE) begin
                    next_state = ST_DECODE; // R11
                end
            end
            ST_DECODE: begin
                if (!addrOk) begin
                    next_state = ST_RECV;
                end else if (sumOk && frameCmd == OP_ROTATE_RIGHT) begin
                    next_state = ST_VMODE; // R4
                end else begin
                    next_state = ST_REPLY;
                end
            end
            ST_VMODE: begin
                next_state = ST_VPARAM; // R2
            end
            ST_VPARAM: begin
                next_state = ST_REPLY;
            end
            ST_REPLY: begin
                if (txDone) begin
                    next_state = ST_RECV;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            state <= ST_RECV;
            rxReady <= 1'b0;
        end else begin
            state <= next_state;
            rxReady <= (next_state == ST_RECV);
        end
    end

    ////////////////////////////////////////////////////////////////
    // accumulator and user variables

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            accu <= RST_WORD;
        end else if (state == ST_DECODE && frameGood && inRange && frameCmd == OP_GET_INDEXED) begin
            accu <= userVar[xIndex[7:0]]; // R8
        end else if (accuLoad) begin
            accu <= accuLoadValue;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < 256; i++) begin
                userVar[i] <= RST_WORD;
            end
        end else if (state == ST_DECODE && frameGood && inRange) begin
            if (frameCmd == OP_SET_INDEXED) begin
                userVar[xIndex[7:0]] <= frameValue; // R5 R7
            end
            if (frameCmd == OP_ACCU_TO_INDEXED) begin
                userVar[xIndex[7:0]] <= accu; // R9
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // axis side of rotate right

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            velocityMode <= 1'b0;
            moveRight <= 1'b0;
            axisParamWrite <= 1'b0;
            axisParamIndex <= RST_BYTE;
            axisParamValue <= RST_WORD;
        end else begin
            axisParamWrite <= (state == ST_VPARAM);
            if (state == ST_VMODE) begin
                velocityMode <= 1'b1; // R2
                moveRight <= 1'b1; // R1
            end
            if (state == ST_VPARAM) begin
                axisParamIndex <= PARAM_TARGET_VELOCITY; // R3
                axisParamValue <= accu; // R1 R3
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // reply

    assign replySum = HOST_ADDR + MODULE_ADDR + replyStatus + frameCmd;

    function automatic logic [7:0] replyByteAt(input logic [3:0] idx, input logic [7:0] st,
        input logic [7:0] cmd, input logic [7:0] sum);
        logic [7:0] b;
        b = RST_BYTE;
        unique case (idx)
            4'h0: b = HOST_ADDR;
            4'h1: b = MODULE_ADDR;
            POS_STATUS: b = st;
            POS_CMD: b = cmd;
            LAST_BYTE: b = sum;
            default: b = RST_BYTE;
        endcase
        return b;
    endfunction

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            replyStatus <= RST_BYTE;
        end else if (state == ST_DECODE) begin
            if (!sumOk) begin
                replyStatus <= STATUS_BAD_SUM; // R12
            end else if (known) begin
                replyStatus <= STATUS_OK; // R10
            end else begin
                replyStatus <= STATUS_BAD_CMD;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            txCount <= RST_COUNT;
            txValid <= 1'b0;
            txByte <= RST_BYTE;
        end else if (state == ST_DECODE) begin
            txCount <= RST_COUNT;
        end else if (state == ST_REPLY && (!txValid || txReady)) begin
            if (txCount == FRAME_LEN) begin
                txValid <= 1'b0;
            end else begin
                txValid <= 1'b1;
                txByte <= replyByteAt(txCount, replyStatus, frameCmd, replySum); // R10
                txCount <= txCount + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstN);

    sequence s_mode_then_param;
        state == ST_VMODE ##1 state == ST_VPARAM && velocityMode ##1 axisParamWrite;
    endsequence

    a_rotate_order: assert property (
        state == ST_DECODE && frameGood && frameCmd == OP_ROTATE_RIGHT |=> s_mode_then_param) // R2
        else $error("rotate right did not select mode then write velocity");
    a_rotate_opcode: assert property (state == ST_VMODE |-> frameCmd == OP_ROTATE_RIGHT) // R4
        else $error("velocity mode entered for another opcode");
    a_velocity_copy: assert property (
        axisParamWrite |-> axisParamValue == $past(accu) && axisParamIndex == PARAM_TARGET_VELOCITY) // R3
        else $error("target velocity not taken from accumulator");
    a_right_dir: assert property (axisParamWrite |-> moveRight && $past(velocityMode)) // R1
        else $error("rotation not toward increasing position");
    a_set_var: assert property (
        state == ST_DECODE && frameGood && inRange && frameCmd == OP_SET_INDEXED
        |=> userVar[$past(xIndex[7:0])] == $past(frameValue)) // R5
        else $error("set indexed did not store value");
    a_range_skip: assert property (
        state == ST_DECODE && !inRange && !accuLoad |=> $stable(accu)) // R6
        else $error("accumulator changed on out of range index");
    a_get_var: assert property (
        state == ST_DECODE && frameGood && inRange && frameCmd == OP_GET_INDEXED
        |=> accu == userVar[$past(xIndex[7:0])]) // R8
        else $error("get indexed did not load accumulator");
    a_store_var: assert property (
        state == ST_DECODE && frameGood && inRange && frameCmd == OP_ACCU_TO_INDEXED
        |=> userVar[$past(xIndex[7:0])] == $past(accu)) // R9
        else $error("accumulator not stored to variable");
    a_reply_ok: assert property (
        state == ST_DECODE && frameGood && known |=> replyStatus == STATUS_OK) // R10
        else $error("known command not answered OK");
    a_sum_gate: assert property (
        state == ST_DECODE && addrOk && !sumOk |=> state == ST_REPLY ##1 !axisParamWrite) // R12
        else $error("bad checksum frame executed");
    a_frame_len: assert property (take && rxCount == LAST_BYTE |=> state == ST_DECODE) // R11
        else $error("ninth byte did not end frame");
endmodule

`default_nettype wire

/* File: verilog/aivc_pkg.sv */
// constants and types of the accumulator and indexed variable command interpreter
`default_nettype none

package aivc_pkg;
    localparam logic [7:0] OP_ROTATE_RIGHT = 8'h33;
    localparam logic [7:0] OP_SET_INDEXED = 8'h37;
    localparam logic [7:0] OP_GET_INDEXED = 8'h38;
    localparam logic [7:0] OP_ACCU_TO_INDEXED = 8'h39;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] PARAM_TARGET_VELOCITY = 8'h02;
    localparam logic [3:0] FRAME_LEN = 4'h9;
    localparam logic [3:0] LAST_BYTE = 4'h8;
    localparam logic [3:0] VALUE_FIRST = 4'h4;
    localparam logic [3:0] POS_STATUS = 4'h2;
    localparam logic [3:0] POS_CMD = 4'h3;
    localparam logic [3:0] RST_COUNT = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0;
    localparam logic [23:0] INDEX_HIGH_ZERO = 24'h0;
    typedef enum logic [2:0] {
        ST_RECV,
        ST_DECODE,
        ST_VMODE,
        ST_VPARAM,
        ST_REPLY
    } aivc_state_type;
endpackage

`default_nettype wire

/* File: bench/aivc_host_model.sv */
// host model that sends command frames and collects reply bytes
`timescale 1ns/10ps
`default_nettype none

module aivc_host_model (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic rxReady,
    input wire logic [7:0] txByte,
    input wire logic txValid,
    output logic [7:0] rxByte,
    output logic rxValid,
    output logic txReady
);
    logic [7:0] reply[$];

    initial begin
        rxByte = 8'h00;
        rxValid = 1'b0;
        txReady = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // reply sink, stalls every other cycle in slow mode
    always @(posedge core_clk) begin
        if (txValid === 1'b1 && txReady === 1'b1) begin
            reply.push_back(txByte);
        end
        txReady <= slow ? ~txReady : 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sender, called just after a rising edge
    task automatic sendFrame(input logic [7:0] addr, input logic [7:0] op, input logic [15:0] care,
                             input logic [31:0] val, input logic badSum);
        logic [71:0] f;
        logic [7:0] s;
        f = {addr, op, care, val, 8'h00};
        s = 8'h00;
        for (int i = 8; i >= 1; i--) begin
            s = s + f[i*8 +: 8];
        end
        f[7:0] = badSum ? ~s : s;
        for (int i = 8; i >= 0; i--) begin
            rxByte <= f[i*8 +: 8];
            rxValid <= 1'b1;
            do @(posedge core_clk); while (rxReady !== 1'b1);
        end
        rxValid <= 1'b0;
        rxByte <= ~f[7:0];
    endtask
endmodule

`default_nettype wire

/* File: bench/tb_accu_indexed_var_cmds.sv */
// self-checking bench of the accumulator and indexed variable interpreter
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_accu_indexed_var_cmds;
    import aivc_pkg::*;
    logic core_clk, nrst, slow, accuLoad, rxReady, rxValid, txValid, txReady;
    logic velocityMode, moveRight, axisParamWrite, capMode;
    logic [7:0] rxByte, txByte, axisParamIndex, capIndex, b;
    logic [31:0] accuLoadValue, xIndex, accu, axisParamValue, capValue, seed, v, w, idx;
    int mismatches, samples_checked, cycles, writes;

    aivc_interp dut (.core_clk(core_clk), .nrst(nrst), .rxByte(rxByte), .rxValid(rxValid), .rxReady(rxReady),
        .txByte(txByte), .txValid(txValid), .txReady(txReady), .accuLoad(accuLoad), .accuLoadValue(accuLoadValue),
        .xIndex(xIndex), .accu(accu), .velocityMode(velocityMode), .moveRight(moveRight),
        .axisParamWrite(axisParamWrite), .axisParamIndex(axisParamIndex), .axisParamValue(axisParamValue));
    aivc_host_model host (.core_clk(core_clk), .slow(slow), .rxReady(rxReady), .txByte(txByte),
        .txValid(txValid), .rxByte(rxByte), .rxValid(rxValid), .txReady(txReady));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic print_verdict;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic runCmd(input logic [7:0] op, input logic [31:0] val, input logic bad, input logic [7:0] st);
        logic [71:0] e;
        logic [7:0] s;
        e = {8'h02, 8'h01, st, op, 32'h0, 8'h00};
        s = 8'h00;
        for (int i = 8; i >= 1; i--) begin
            s = s + e[i*8 +: 8];
        end
        e[7:0] = s;
        seed = lfsrNext(seed);
        host.sendFrame(8'h01, op, seed[15:0], val, bad);
        while (host.reply.size() < 9) @(posedge core_clk);
        for (int i = 8; i >= 0; i--) begin
            b = host.reply.pop_front();
            `CHK(b, e[i*8 +: 8])
        end
    endtask

    task automatic loadAccu(input logic [31:0] val);
        accuLoad <= 1'b1;
        accuLoadValue <= val;
        @(posedge core_clk);
        accuLoad <= 1'b0;
        @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (axisParamWrite === 1'b1) begin
            writes++;
            capIndex = axisParamIndex;
            capValue = axisParamValue;
            capMode = velocityMode;
        end
        if (cycles > 30000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        nrst = 1'b0;
        slow = 1'b0;
        accuLoad = 1'b0;
        accuLoadValue = 32'h0;
        xIndex = 32'h0;
        seed = 32'h9d3e;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            seed = lfsrNext(seed);
            slow <= seed[5];
            idx = (k == 0) ? 32'h0 : (k == 1) ? 32'hff : {24'h0, seed[15:8]};
            v = lfsrNext(seed);
            w = ~v ^ seed;
            xIndex <= idx;
            runCmd(OP_SET_INDEXED, v, 1'b0, STATUS_OK);
            runCmd(OP_GET_INDEXED, 32'h0, 1'b0, STATUS_OK);
            `CHK(accu, v)
            loadAccu(w);
            runCmd(OP_ACCU_TO_INDEXED, 32'h0, 1'b0, STATUS_OK);
            loadAccu(32'h0);
            runCmd(OP_GET_INDEXED, 32'h0, 1'b0, STATUS_OK);
            `CHK(accu, w)
            // out of range index whose low byte aliases the live entry
            xIndex <= {seed[0] ? 24'hffffff : (seed[31:8] | 24'h1), idx[7:0]};
            runCmd(OP_SET_INDEXED, v, 1'b0, STATUS_OK);
            loadAccu(~w);
            runCmd(OP_ACCU_TO_INDEXED, 32'h0, 1'b0, STATUS_OK);
            runCmd(OP_GET_INDEXED, 32'h0, 1'b0, STATUS_OK);
            `CHK(accu, ~w)
            xIndex <= idx;
            runCmd(OP_SET_INDEXED, v, 1'b1, STATUS_BAD_SUM);
            runCmd(OP_GET_INDEXED, 32'h0, 1'b0, STATUS_OK);
            `CHK(accu, w)
            // frame for another module: no reply, nothing executed
            host.sendFrame({seed[7:1], 1'b0}, OP_SET_INDEXED, 16'h0, v, 1'b0);
            repeat (12) @(posedge core_clk);
            `CHK(host.reply.size(), 0)
            runCmd(OP_GET_INDEXED, 32'h0, 1'b0, STATUS_OK);
            `CHK(accu, w)
            writes = 0;
            runCmd(8'h80 | seed[7:0], 32'h0, 1'b0, STATUS_BAD_CMD);
            `CHK(accu, w)
            loadAccu(v);
            runCmd(OP_ROTATE_RIGHT, seed, 1'b0, STATUS_OK);
            `CHK(writes, 1)
            `CHK(capIndex, PARAM_TARGET_VELOCITY)
            `CHK(capValue, v)
            `CHK(capMode, 1'b1)
            `CHK(moveRight, 1'b1)
        end
        print_verdict();
    end
endmodule

`default_nettype wire
